// file: src/mic_pkg.sv
// constants and carrier types for the maskable interrupt control block
package mic_pkg;

  localparam int NSRC = 8;                 // peripheral sources handled here

  // axi4-lite register byte offsets and response codes
  localparam logic [7:0] OFF_PFLAG  = 8'h00; // processor flag word
  localparam logic [7:0] OFF_HSP    = 8'h04; // handler stack pointer
  localparam logic [7:0] OFF_USRSP  = 8'h08; // user stack pointer
  localparam logic [7:0] OFF_VTB    = 8'h0c; // vector table base
  localparam logic [7:0] OFF_STATUS = 8'h10; // sequencer state, last accept
  localparam logic [7:0] OFF_INFO   = 8'h14; // interrupt information (00000h)
  localparam logic [7:0] OFF_SRC0   = 8'h20; // source i at OFF_SRC0 + 4*i
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  // processor flag word fields
  localparam int PF_BANK = 4;
  localparam int PF_DSTEP = 5;
  localparam int PF_GIE = 6;
  localparam int PF_USEL = 7;
  localparam int PF_PPL_LO = 12;
  localparam int PF_HI_LO = 12;            // upper four flag bits stacked
  localparam logic [15:0] PFLAG_RST = 16'h0000;

  // source register fields: level in [2:0], pending in [3]
  localparam int SRC_PEND = 3;

  // levels
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic [2:0] LVL_MAX = 3'h7;

  // trap numbers that keep the stack-select flag
  localparam logic [5:0] TRAP_KEEP_LO = 6'h20;

  // fixed vectors of special sources, information address and stack step sizes
  localparam logic [19:0] VEC_WDT_OSC = 20'hffff0;
  localparam logic [19:0] VEC_NMI     = 20'hffff8;
  localparam logic [19:0] INFO_ADDR   = 20'h00000;
  localparam logic [19:0] WORD_BYTES  = 20'h00002;
  localparam logic [19:0] FRAME_BYTES = 20'h00004;
  localparam logic [19:0] ONE_BYTE    = 20'h00001;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_INFO  = 4'b0001,
    ST_FLAGS = 4'b0010,
    ST_W1    = 4'b0011,
    ST_W1B   = 4'b0100,
    ST_W2    = 4'b0101,
    ST_W2B   = 4'b0110,
    ST_PPL   = 4'b0111,
    ST_VEC0  = 4'b1000,
    ST_VEC1  = 4'b1001,
    ST_VEC2  = 4'b1010
  } mic_state_t;

  typedef enum logic [1:0] {
    KIND_MASK = 2'b00,
    KIND_NMI  = 2'b01,
    KIND_WDT  = 2'b10,
    KIND_TRAP = 2'b11
  } mic_kind_t;

  // stack write port towards memory
  typedef struct packed {
    logic        wr;
    logic        byte_en;   // 1: single byte in data[7:0]
    logic [19:0] addr;
    logic [15:0] data;
  } mic_stack_wr_t;

  // all state of the block
  typedef struct packed {
    mic_state_t          st;
    logic [NSRC-1:0]     pend;
    logic [NSRC*3-1:0]   lvl;
    logic [15:0]         pflag;
    logic [15:0]         tmp;
    logic [19:0]         hsp;
    logic [19:0]         usr_sp;
    logic [19:0]         vtb;
    logic [19:0]         sp_work;
    logic [19:0]         pc_save;
    logic [5:0]          num;
    logic [2:0]          acc_lvl;
    mic_kind_t           kind;
    logic [$clog2(NSRC)-1:0] acc_idx;
    logic                sp_user;
    logic                nmi_p;
    logic                wdt_p;
    logic                osc_p;
    logic [15:0]         vec_lo;
    mic_stack_wr_t       sw;
    logic                vec_rd;
    logic [19:0]         vec_addr;
    logic                pc_ld;
    logic [19:0]         pc_new;
    logic                suspend;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
  } mic_regs_t;

endpackage

// file: src/mic_top.sv
// maskable interrupt acceptance, entry sequence and register slave
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module mic_top
  import mic_pkg::*;
#(
  parameter bit         LOW_NUM_FIRST = 1'b1,  // equal-level tie-break
  parameter logic [5:0] SRC_NUM_BASE  = 6'h15  // number of source 0
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write address and data
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // axi4-lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // axi4-lite read
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // request sources, one-cycle pulses
  input  wire logic [NSRC-1:0]      src_req,
  input  wire logic                 nmi_req,
  input  wire logic                 wdt_req,
  input  wire logic                 osc_req,
  // core sequencing
  input  wire logic                 inst_done,
  input  wire logic                 rep_busy,
  input  wire logic                 trap_req,
  input  wire logic [5:0]           trap_num,
  input  wire logic [19:0]          cur_pc,
  input  wire logic                 ret_req,
  input  wire logic [15:0]          ret_flags,
  // memory side
  output mic_pkg::mic_stack_wr_t    stack_wr,
  output logic                      vec_rd,
  output logic [19:0]               vec_addr,
  input  wire logic [15:0]          vec_rdata,
  // results towards the core
  output logic                      pc_load,
  output logic [19:0]               pc_new,
  output logic                      core_suspend,
  output logic                      seq_busy,
  output logic [15:0]               pflag_out
);

  import mic_pkg::*;

  localparam int IW = $clog2(NSRC);

  mic_regs_t r_r;
  mic_regs_t r_nxt;

  // arbitration result, recomputed from registered state each cycle
  logic          win_ok;
  logic [IW-1:0] win_idx;
  logic [2:0]    win_lvl;
  logic [2:0]    ppl;

  assign ppl = r_r.pflag[PF_PPL_LO +: 3];

  // highest eligible maskable source, tie rank by parameter
  always_comb begin
    logic [2:0] l;
    l = LVL_OFF;
    win_ok = 1'b0;
    win_idx = '0;
    win_lvl = LVL_OFF;
    for (int i = 0; i < NSRC; i++) begin
      l = r_r.lvl[3*i +: 3];
      // level 0 and levels not above ppl drop out
      if (r_r.pend[i] && l != LVL_OFF && l > ppl) begin
        if (!win_ok || l > win_lvl || (l == win_lvl && !LOW_NUM_FIRST)) begin
          win_ok = 1'b1;
          win_idx = IW'(i);
          win_lvl = l;
        end
      end
    end
  end

  // next-state logic for the whole block
  always_comb begin
    logic          sample;
    logic          mask_go;
    logic          aw_go;
    logic          ar_go;
    logic [7:0]    idx_off;
    logic [IW:0]   sidx;
    logic [15:0]   word1;
    logic [19:0]   sp_sel;
    logic [NSRC-1:0] clr;
    logic [31:0]   rd;
    logic          rd_err;
    sample = 1'b0;
    mask_go = 1'b0;
    aw_go = 1'b0;
    ar_go = 1'b0;
    idx_off = 8'h00;
    sidx = '0;
    word1 = 16'h0000;
    sp_sel = 20'h00000;
    clr = '0;
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    r_nxt = r_r;
    r_nxt.sw.wr = 1'b0;
    r_nxt.vec_rd = 1'b0;
    r_nxt.pc_ld = 1'b0;
    r_nxt.suspend = 1'b0;

    // special pending flags; hardware events, no software clear
    if (nmi_req) r_nxt.nmi_p = 1'b1;
    if (wdt_req) r_nxt.wdt_p = 1'b1;
    if (osc_req) r_nxt.osc_p = 1'b1;

    // sampling at instruction end or inside an interruptible repeat
    sample = (r_r.st == ST_IDLE) && (inst_done || rep_busy);
    mask_go = win_ok && r_r.pflag[PF_GIE];

    if (sample) begin
      // specials beat traps beat maskable
      if (r_r.nmi_p || r_r.wdt_p || r_r.osc_p) begin
        r_nxt.kind = r_r.nmi_p ? KIND_NMI : KIND_WDT;
        r_nxt.acc_lvl = LVL_MAX;
        r_nxt.num = 6'h00;
        if (r_r.nmi_p) r_nxt.nmi_p = nmi_req;
        else if (r_r.wdt_p) r_nxt.wdt_p = wdt_req;
        else r_nxt.osc_p = osc_req;
        r_nxt.st = ST_FLAGS;
      end else if (trap_req && inst_done) begin
        r_nxt.kind = KIND_TRAP;                // level left as is
        r_nxt.acc_lvl = ppl;
        r_nxt.num = trap_num;
        r_nxt.st = ST_FLAGS;
      end else if (mask_go) begin
        r_nxt.kind = KIND_MASK;
        r_nxt.acc_idx = win_idx;
        r_nxt.acc_lvl = win_lvl;
        r_nxt.num = SRC_NUM_BASE + 6'(win_idx);
        r_nxt.st = ST_INFO;
      end
      if (r_nxt.st != ST_IDLE) begin
        r_nxt.pc_save = cur_pc;
        r_nxt.suspend = rep_busy && !inst_done;
      end
    end

    // stack choice fixed in the flags step, first word built
    sp_sel = r_r.sp_user ? r_r.usr_sp : r_r.hsp;
    word1 = {r_r.pc_save[19:16], r_r.tmp[15:PF_HI_LO], r_r.tmp[7:0]};

    case (r_r.st)
      ST_IDLE: begin
      end
      ST_INFO: begin
        clr[r_r.acc_idx] = 1'b1;
        r_nxt.st = ST_FLAGS;
      end
      ST_FLAGS: begin
        r_nxt.tmp = r_r.pflag;
        r_nxt.pflag[PF_GIE] = 1'b0;
        r_nxt.pflag[PF_DSTEP] = 1'b0;
        if (r_r.kind == KIND_TRAP && r_r.num >= TRAP_KEEP_LO) begin
          r_nxt.sp_user = r_r.pflag[PF_USEL];
        end else begin
          r_nxt.pflag[PF_USEL] = 1'b0;
          r_nxt.sp_user = 1'b0;
        end
        r_nxt.st = ST_W1;
      end
      ST_W1: begin
        r_nxt.sw.wr = 1'b1;
        r_nxt.sp_work = sp_sel;
        if (sp_sel[0]) begin                   // odd: two bytes
          r_nxt.sw.byte_en = 1'b1;
          r_nxt.sw.addr = sp_sel - ONE_BYTE;
          r_nxt.sw.data = {8'h00, word1[15:8]};
          r_nxt.st = ST_W1B;
        end else begin
          r_nxt.sw.byte_en = 1'b0;
          r_nxt.sw.addr = sp_sel - WORD_BYTES;
          r_nxt.sw.data = word1;
          r_nxt.st = ST_W2;
        end
      end
      ST_W1B: begin
        r_nxt.sw.wr = 1'b1;
        r_nxt.sw.addr = r_r.sp_work - WORD_BYTES;
        r_nxt.sw.data = {8'h00, word1[7:0]};
        r_nxt.st = ST_W2;
      end
      ST_W2: begin
        r_nxt.sw.wr = 1'b1;
        r_nxt.sw.addr = r_r.sp_work - WORD_BYTES - (r_r.sp_work[0] ?
                        ONE_BYTE : WORD_BYTES);
        r_nxt.sw.data = r_r.sp_work[0] ? {8'h00, r_r.pc_save[15:8]} :
                        r_r.pc_save[15:0];
        r_nxt.st = r_r.sp_work[0] ? ST_W2B : ST_PPL;
      end
      ST_W2B: begin
        r_nxt.sw.wr = 1'b1;
        r_nxt.sw.addr = r_r.sp_work - FRAME_BYTES;
        r_nxt.sw.data = {8'h00, r_r.pc_save[7:0]};
        r_nxt.st = ST_PPL;
      end
      ST_PPL: begin
        r_nxt.pflag[PF_PPL_LO +: 3] = r_r.acc_lvl;
        if (r_r.sp_user) r_nxt.usr_sp = r_r.sp_work - FRAME_BYTES;
        else r_nxt.hsp = r_r.sp_work - FRAME_BYTES;
        r_nxt.vec_rd = 1'b1;
        case (r_r.kind)
          KIND_NMI: r_nxt.vec_addr = VEC_NMI;
          KIND_WDT: r_nxt.vec_addr = VEC_WDT_OSC;
          default:  r_nxt.vec_addr = r_r.vtb + {12'h000, r_r.num, 2'b00};
        endcase
        r_nxt.st = ST_VEC0;
      end
      ST_VEC0: begin
        r_nxt.vec_rd = 1'b1;                   // upper half of entry
        r_nxt.vec_addr = r_r.vec_addr + WORD_BYTES;
        r_nxt.st = ST_VEC1;
      end
      ST_VEC1: begin
        r_nxt.vec_lo = vec_rdata;
        r_nxt.st = ST_VEC2;
      end
      ST_VEC2: begin
        r_nxt.pc_ld = 1'b1;
        r_nxt.pc_new = {vec_rdata[3:0], r_r.vec_lo};
        r_nxt.st = ST_IDLE;
      end
      default: r_nxt.st = ST_IDLE;
    endcase

    // return restores flags, level and bank
    if (ret_req && r_r.st == ST_IDLE) begin
      r_nxt.pflag = ret_flags;
      if (r_r.pflag[PF_USEL]) r_nxt.usr_sp = r_r.usr_sp + FRAME_BYTES;
      else r_nxt.hsp = r_r.hsp + FRAME_BYTES;
    end

    // axi write: both channels taken on one edge
    aw_go = r_r.awready && s_axi_awvalid && s_axi_wvalid;
    if (!r_r.awready && !r_r.bvalid && s_axi_awvalid && s_axi_wvalid) begin
      r_nxt.awready = 1'b1;
      r_nxt.wready = 1'b1;
    end
    if (aw_go) begin
      r_nxt.awready = 1'b0;
      r_nxt.wready = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = RESP_OKAY;
      idx_off = s_axi_awaddr - OFF_SRC0;
      sidx = (IW + 1)'(idx_off[7:2]);
      if (s_axi_awaddr == OFF_PFLAG) begin
        if (s_axi_wstrb[0]) r_nxt.pflag[7:0] = s_axi_wdata[7:0];
        if (s_axi_wstrb[1]) r_nxt.pflag[15:8] = s_axi_wdata[15:8];
      end else if (s_axi_awaddr == OFF_HSP && s_axi_wstrb[0]) begin
        r_nxt.hsp = s_axi_wdata[19:0];
      end else if (s_axi_awaddr == OFF_USRSP && s_axi_wstrb[0]) begin
        r_nxt.usr_sp = s_axi_wdata[19:0];
      end else if (s_axi_awaddr == OFF_VTB && s_axi_wstrb[0]) begin
        r_nxt.vtb = s_axi_wdata[19:0];
      end else if (s_axi_awaddr >= OFF_SRC0 && s_axi_awaddr[1:0] == 2'b00
                   && idx_off[7:2] < 6'(NSRC)) begin
        if (s_axi_wstrb[0]) begin
          // level alone; pending only cleared by 0
          r_nxt.lvl[3*sidx[IW-1:0] +: 3] = s_axi_wdata[2:0];
          if (!s_axi_wdata[SRC_PEND]) clr[sidx[IW-1:0]] = 1'b1;
        end
      end else if (s_axi_awaddr != OFF_STATUS
                   && s_axi_awaddr != OFF_INFO) begin
        r_nxt.bresp = RESP_SLV;
      end
    end
    if (r_r.bvalid && s_axi_bready) r_nxt.bvalid = 1'b0;

    // axi read
    ar_go = r_r.arready && s_axi_arvalid;
    if (!r_r.arready && !r_r.rvalid && s_axi_arvalid) r_nxt.arready = 1'b1;
    if (ar_go) begin
      r_nxt.arready = 1'b0;
      idx_off = s_axi_araddr - OFF_SRC0;
      sidx = (IW + 1)'(idx_off[7:2]);
      case (s_axi_araddr)
        OFF_PFLAG:  rd = {16'h0000, r_r.pflag};
        OFF_HSP:    rd = {12'h000, r_r.hsp};
        OFF_USRSP:  rd = {12'h000, r_r.usr_sp};
        OFF_VTB:    rd = {12'h000, r_r.vtb};
        OFF_STATUS: rd = {16'h0000, r_r.acc_lvl, r_r.num, r_r.kind,
                          r_r.nmi_p | r_r.wdt_p | r_r.osc_p, r_r.st};
        OFF_INFO: begin
          // information read clears the winner
          rd = {16'h0000, 4'h0, win_ok, win_lvl,
                2'b00, SRC_NUM_BASE + 6'(win_idx)};
          if (win_ok) clr[win_idx] = 1'b1;
        end
        default: begin
          if (s_axi_araddr >= OFF_SRC0 && s_axi_araddr[1:0] == 2'b00
              && idx_off[7:2] < 6'(NSRC)) begin
            rd = {28'h0000000, r_r.pend[sidx[IW-1:0]],
                  r_r.lvl[3*sidx[IW-1:0] +: 3]};
          end else begin
            rd_err = 1'b1;
          end
        end
      endcase
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata = rd;
      r_nxt.rresp = rd_err ? RESP_SLV : RESP_OKAY;
    end
    if (r_r.rvalid && s_axi_rready) r_nxt.rvalid = 1'b0;

    // pending flags: a new request wins over any clear
    r_nxt.pend = (r_r.pend & ~clr) | src_req;
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r <= '0;
      r_r.st <= ST_IDLE;
      r_r.kind <= KIND_MASK;
      r_r.pflag <= PFLAG_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs come straight from the state register
  assign s_axi_awready = r_r.awready;
  assign s_axi_wready  = r_r.wready;
  assign s_axi_bvalid  = r_r.bvalid;
  assign s_axi_bresp   = r_r.bresp;
  assign s_axi_arready = r_r.arready;
  assign s_axi_rvalid  = r_r.rvalid;
  assign s_axi_rdata   = r_r.rdata;
  assign s_axi_rresp   = r_r.rresp;
  assign stack_wr      = r_r.sw;
  assign vec_rd        = r_r.vec_rd;
  assign vec_addr      = r_r.vec_addr;
  assign pc_load       = r_r.pc_ld;
  assign pc_new        = r_r.pc_new;
  assign core_suspend  = r_r.suspend;
  assign seq_busy      = (r_r.st != ST_IDLE);
  assign pflag_out     = r_r.pflag;

endmodule

`default_nettype wire

// file: testbench/mic_mem_model.sv
// memory-side partner: vector table and a log of stack pushes
`timescale 1ns/1ps
`default_nettype none

module mic_mem_model (
  // clock
  input  wire logic                   aclk,
  // pushes and vector reads from the block
  input  wire mic_pkg::mic_stack_wr_t stack_wr,
  input  wire logic                   vec_rd,
  input  wire logic [19:0]            vec_addr,
  // vector halfword, valid the cycle after a read
  output logic [15:0]                 vec_rdata
);
  import mic_pkg::*;
  logic [36:0] wq[$];

  // each halfword holds its inverted address; between reads the bus
  // toggles so a late sample never matches by luck
  always @(posedge aclk) begin
    if (vec_rd)
      vec_rdata <= ~vec_addr[15:0];
    else
      vec_rdata <= ~vec_rdata;
    if (stack_wr.wr) // byte pushes carry only the low lane
      wq.push_back({stack_wr.byte_en, stack_wr.addr,
        stack_wr.byte_en ? {8'h00, stack_wr.data[7:0]} : stack_wr.data});
  end
  initial vec_rdata = 16'h0000;
endmodule
`default_nettype wire

// file: testbench/mic_top_properties.sv
// port-level checker of the entry sequence and flag stability
`timescale 1ns/1ps
`default_nettype none

module mic_top_properties (
  // clock and reset
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // inputs seen by the block
  input wire logic                   s_axi_wvalid,
  input wire logic                   inst_done,
  input wire logic                   rep_busy,
  input wire logic                   ret_req,
  // outputs of the block
  input wire mic_pkg::mic_stack_wr_t stack_wr,
  input wire logic                   vec_rd,
  input wire logic [19:0]            vec_addr,
  input wire logic                   pc_load,
  input wire logic                   core_suspend,
  input wire logic                   seq_busy,
  input wire logic [15:0]            pflag_out
);
  import mic_pkg::*;
  logic quiet;
  // nothing that may rewrite the flags is active
  assign quiet = !seq_busy && !s_axi_wvalid && !ret_req;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  busy_cause_a: assert property (
    $rose(seq_busy) |-> $past(inst_done || rep_busy))
    else $error("entry without sampling point");
  load_bound_a: assert property (
    $rose(seq_busy) |-> ##[1:14] pc_load)
    else $error("entry did not load the counter");
  word_align_a: assert property (
    stack_wr.wr && !stack_wr.byte_en |-> !stack_wr.addr[0])
    else $error("word push at odd address");
  push_order_a: assert property (
    stack_wr.wr |-> seq_busy && !vec_rd && !pc_load)
    else $error("push outside its step");
  gie_clear_a: assert property (
    pc_load |-> !pflag_out[PF_GIE] && !pflag_out[PF_DSTEP])
    else $error("flags not cleared on entry");
  flags_hold_a: assert property (
    quiet && $past(quiet) && $past(quiet, 2) |-> $stable(pflag_out))
    else $error("flags changed while idle");
  suspend_a: assert property (
    $rose(seq_busy) && $past(rep_busy && !inst_done)
      |-> ##[0:2] core_suspend)
    else $error("repeat not suspended");
  vec_pair_a: assert property (
    vec_rd ##1 vec_rd |-> vec_addr == $past(vec_addr) + 20'h2
      ##[1:3] pc_load)
    else $error("vector halves out of step");

  // main scenarios reached
  odd_push_c: cover property (stack_wr.wr && stack_wr.byte_en);
  suspend_c: cover property (core_suspend);
  return_c: cover property (ret_req && !seq_busy);
endmodule

bind mic_top mic_top_properties i_mic_top_properties (
  .aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
  .inst_done(inst_done), .rep_busy(rep_busy), .ret_req(ret_req),
  .stack_wr(stack_wr), .vec_rd(vec_rd), .vec_addr(vec_addr),
  .pc_load(pc_load), .core_suspend(core_suspend),
  .seq_busy(seq_busy), .pflag_out(pflag_out));
`default_nettype wire

// file: testbench/mic_top_tb_top.sv
// bench for the maskable interrupt control block
`timescale 1ns/1ps
`default_nettype none

module mic_top_tb_top;
  import mic_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0;
  logic rry = 0, nmi = 0, done = 0, rep = 0, ret = 0, susp;
  logic trap = 0, wdt = 0;
  logic [5:0] tnum = 0;
  logic awr, wrdy, bv, arr, rv, ld, sus, busy, vrd;
  logic [7:0] awa = 0, ara = 0, src = 0;
  logic [31:0] wd = 0, rdat;
  logic [1:0] br, rr;
  logic [19:0] pc = 0, pcn, va;
  logic [15:0] rflg = 0, vdat, processor_flag_register;
  mic_stack_wr_t sw;
  int miscompares = 0, num_checks = 0;

  // oscillator input stays idle; it shares the watchdog path
  mic_top i_mic_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .src_req(src),
    .nmi_req(nmi), .wdt_req(wdt), .osc_req(1'b0), .inst_done(done),
    .rep_busy(rep), .trap_req(trap), .trap_num(tnum), .cur_pc(pc),
    .ret_req(ret), .ret_flags(rflg), .stack_wr(sw), .vec_rd(vrd),
    .vec_addr(va), .vec_rdata(vdat), .pc_load(ld), .pc_new(pcn),
    .core_suspend(sus), .seq_busy(busy), .pflag_out(processor_flag_register));
  mic_mem_model i_mic_mem_model (.aclk(aclk), .stack_wr(sw),
    .vec_rd(vrd), .vec_addr(va), .vec_rdata(vdat));
  always #50 aclk = ~aclk;

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a wait that ran out ends the run
  task automatic limit(input int n);
    if (n >= 40) begin
      miscompares++;
      conclude();
    end
  endtask

  // each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    limit(n);
    chk("bresp", er, br);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    limit(n);
    chk("rresp", er, rr);
    chk("rdata", e, rdat);
  endtask

  task automatic fire(input logic [7:0] s);
    src <= s;
    @(posedge aclk);
    src <= 8'h00;
  endtask

  // one sampling point, or a repeat instruction left running
  task automatic step(input logic [19:0] p, input logic r);
    pc <= p;
    done <= !r;
    rep <= r;
    @(posedge aclk);
    done <= 1'b0;
  endtask

  task automatic land(input logic [19:0] e);
    int n;
    susp = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (sus === 1'b1) susp = 1'b1;
      if (ld === 1'b1) break;
    end
    limit(n);
    chk("pc_new", e, pcn);
  endtask

  task automatic refuse;
    int n;
    logic b;
    b = 1'b0;
    step(20'h00100, 1'b0);
    for (n = 0; n < 4; n++) begin
      @(posedge aclk);
      if (busy !== 1'b0) b = 1'b1;
    end
    chk("refused", 1'b0, b);
  endtask

  function automatic logic [19:0] vpc(input logic [19:0] v);
    logic [19:0] h;
    h = v + 20'h2;
    return {~h[3:0], ~v[15:0]};
  endfunction

  function automatic logic [36:0] pu(input int i);
    return i_mic_mem_model.wq[i];
  endfunction

  task automatic t_entry;
    rd(OFF_PFLAG, 32'h0, RESP_OKAY);
    wr(8'h18, 32'h1, RESP_SLV);
    wr(OFF_PFLAG, 32'h2040, RESP_OKAY);
    wr(OFF_HSP, 32'h100, RESP_OKAY);
    wr(OFF_VTB, 32'h1000, RESP_OKAY);
    wr(OFF_SRC0, 32'h3, RESP_OKAY);
    wr(OFF_SRC0 + 8'h4, 32'h5, RESP_OKAY);
    fire(8'h03);
    step(20'h5abcd, 1'b0);
    land(vpc(20'h01058));
    chk("flags", 16'h5000, processor_flag_register);
    chk("pushes", 2, i_mic_mem_model.wq.size());
    chk("push0", {1'b0, 20'h000fe, 16'h5240}, pu(0));
    chk("push1", {1'b0, 20'h000fc, 16'habcd}, pu(1));
    rd(OFF_SRC0 + 8'h4, 32'h5, RESP_OKAY);
    rd(OFF_SRC0, 32'hb, RESP_OKAY);
  endtask

  // return restores bank and level, then odd stack byte pushes
  task automatic t_ret;
    rflg <= 16'h2050;
    ret <= 1'b1;
    @(posedge aclk);
    ret <= 1'b0;
    wr(OFF_HSP, 32'h101, RESP_OKAY);
    chk("flags", 16'h2050, processor_flag_register);
    i_mic_mem_model.wq.delete();
    step(20'h12345, 1'b0);
    land(vpc(20'h01054));
    chk("flags", 16'h3010, processor_flag_register);
    chk("pushes", 4, i_mic_mem_model.wq.size());
    chk("push0", {1'b1, 20'h00100, 16'h0012}, pu(0));
    chk("push1", {1'b1, 20'h000ff, 16'h0050}, pu(1));
    chk("push2", {1'b1, 20'h000fe, 16'h0023}, pu(2));
    chk("push3", {1'b1, 20'h000fd, 16'h0045}, pu(3));
  endtask

  // gating by enable and level, then the pin source bypasses it
  task automatic t_gate;
    fire(8'h02);
    refuse();
    wr(OFF_PFLAG, 32'h7040, RESP_OKAY);
    refuse();
    wr(OFF_PFLAG, 32'h5040, RESP_OKAY);
    refuse();
    rd(OFF_SRC0 + 8'h4, 32'hd, RESP_OKAY);
    wr(OFF_PFLAG, 32'h4040, RESP_OKAY);
    step(20'h00200, 1'b0);
    land(vpc(20'h01058));
    nmi <= 1'b1;
    @(posedge aclk);
    nmi <= 1'b0;
    step(20'h00300, 1'b0);
    land(vpc(VEC_NMI));
    chk("flags", 16'h7000, processor_flag_register);
  endtask

  task automatic t_clear;
    wr(OFF_SRC0 + 8'h8, 32'h2, RESP_OKAY);
    fire(8'h04);
    rd(OFF_SRC0 + 8'h8, 32'ha, RESP_OKAY);
    wr(OFF_SRC0 + 8'h8, 32'ha, RESP_OKAY);
    rd(OFF_SRC0 + 8'h8, 32'ha, RESP_OKAY);
    wr(OFF_SRC0 + 8'h8, 32'h2, RESP_OKAY);
    rd(OFF_SRC0 + 8'h8, 32'h2, RESP_OKAY);
    fire(8'h04);
    wr(OFF_PFLAG, 32'h0040, RESP_OKAY);
    rd(OFF_INFO, 32'ha17, RESP_OKAY);
    rd(OFF_SRC0 + 8'h8, 32'h2, RESP_OKAY);
  endtask

  task automatic t_rep;
    wr(OFF_SRC0 + 8'hc, 32'h1, RESP_OKAY);
    fire(8'h08);
    step(20'h00400, 1'b1);
    land(vpc(20'h01060));
    rep <= 1'b0;
    chk("suspend", 1'b1, susp);
  endtask

  // trap keeps the user stack while disabled, then watchdog sets level 7
  task automatic t_trap;
    wr(OFF_PFLAG, 32'h1080, RESP_OKAY);
    wr(OFF_USRSP, 32'h200, RESP_OKAY);
    i_mic_mem_model.wq.delete();
    tnum <= 6'h21;
    trap <= 1'b1;
    step(20'h00500, 1'b0);
    trap <= 1'b0;
    land(vpc(20'h01084));
    chk("flags", 16'h1080, processor_flag_register);
    chk("push0", {1'b0, 20'h001fe, 16'h0180}, pu(0));
    chk("push1", {1'b0, 20'h001fc, 16'h0500}, pu(1));
    rd(OFF_USRSP, 32'h1fc, RESP_OKAY);
    wdt <= 1'b1;
    @(posedge aclk);
    wdt <= 1'b0;
    step(20'h00600, 1'b0);
    land(vpc(VEC_WDT_OSC));
    chk("flags", 16'h7000, processor_flag_register);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_entry();
    t_ret();
    t_gate();
    t_clear();
    t_rep();
    t_trap();
    conclude();
  end
endmodule
`default_nettype wire
